// file: hw/adm_consts.vh
`ifndef ADM_CONSTS_VH
`define ADM_CONSTS_VH

// Register indices; the byte address is four times the index.
`define ADM_IDX_ATTEN_CH1      5'h01
`define ADM_IDX_ATTEN_CH6      5'h06
`define ADM_IDX_MUTE_LOW       5'h07
`define ADM_IDX_CHAN_EN_LOW    5'h08
`define ADM_IDX_FMT_FILT       5'h09
`define ADM_IDX_DEEMPH_PHASE   5'h0a
`define ADM_IDX_READBACK_CTL   5'h0b
`define ADM_IDX_SPARE_OUT_CTL  5'h0c
`define ADM_IDX_ATTEN_CH7      5'h10
`define ADM_IDX_ATTEN_CH8      5'h11
`define ADM_IDX_MUTE_HIGH      5'h12
`define ADM_IDX_CHAN_EN_HIGH   5'h13
`define ADM_IDX_READBACK_DATA  5'h14

// Reset values.
`define ADM_RST_ATTEN          8'hff
`define ADM_RST_READBACK_CTL   8'h01
`define ADM_RST_OTHER          8'h00

// Field positions.
`define ADM_FMT_LSB            0
`define ADM_FMT_MSB            2
`define ADM_ROLLOFF_BIT        4
`define ADM_DEEMPH_RATE_LSB    0
`define ADM_DEEMPH_RATE_MSB    1
`define ADM_DEEMPH_ON_BIT      4
`define ADM_OUT_INVERT_BIT     5
`define ADM_ZERO_POL_BIT       6
`define ADM_RB_INDEX_LSB       0
`define ADM_RB_INDEX_MSB       6
`define ADM_RB_AUTOINC_BIT     7
`define ADM_SPARE_BITS_LSB     0
`define ADM_SPARE_BITS_MSB     5
`define ADM_SPARE_EN_BIT       6
`define ADM_OVERSAMPLE_BIT     7
`define ADM_EN_HIGH_LSB        0
`define ADM_EN_HIGH_MSB        1

// Write and read responses.
`define ADM_RESP_OKAY          2'h0

`endif

// file: hw/adm_regs.v
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "adm_consts.vh"

module adm_regs
(
	input  wire        CLK_SYS_I,
	input  wire        ARST_N_I,
	input  wire        AWVALID_I,
	output wire        AWREADY_O,
	input  wire [6:0]  AWADDR_I,
	input  wire        WVALID_I,
	output wire        WREADY_O,
	input  wire [31:0] WDATA_I,
	input  wire [3:0]  WSTRB_I,
	output wire        BVALID_O,
	input  wire        BREADY_I,
	output wire [1:0]  BRESP_O,
	input  wire        ARVALID_I,
	output wire        ARREADY_O,
	input  wire [6:0]  ARADDR_I,
	output wire        RVALID_O,
	input  wire        RREADY_I,
	output wire [31:0] RDATA_O,
	output wire [1:0]  RRESP_O,
	input  wire [5:0]  ZERO_DET_I,
	output wire [63:0] GAIN_STEP_O,
	output wire [7:0]  SILENCE_MASK_O,
	output wire [7:0]  CHAN_ENABLE_O,
	output wire [2:0]  INTERFACE_LAYOUT_O,
	output wire        ROLLOFF_SELECT_O,
	output wire        DEEMPH_ON_O,
	output wire [1:0]  DEEMPH_RATE_O,
	output wire        OUTPUT_INVERT_O,
	output wire        OVERSAMPLE_O,
	output wire [5:0]  SHARED_PIN_O
);

	reg        awready_ff;
	reg        wready_ff;
	reg        bvalid_ff;
	reg        arready_ff;
	reg        rvalid_ff;
	reg [31:0] rdata_ff;
	reg        aw_hold_ff;
	reg [4:0]  aw_idx_ff;
	reg        w_hold_ff;
	reg [7:0]  w_data_ff;
	reg        w_strb_ff;
	reg [5:0]  shared_ff;
	reg [63:0] gain_ff;
	reg [7:0]  silence_ff;
	reg [7:0]  enable_ff;
	reg [7:0]  fmt_ff;
	reg [7:0]  deemph_ff;
	reg [7:0]  spare_ff;

	wire [7:0] reg_q [0:31];
	wire       aw_take;
	wire       w_take;
	wire       aw_have;
	wire       w_have;
	wire       do_write;
	wire [4:0] wr_idx;
	wire [7:0] wr_data;
	wire       wr_strb;
	wire       ar_take;
	wire [4:0] rd_idx;
	wire       rb_pop;
	wire [7:0] rb_value;
	wire [7:0] rb_ctl;
	wire       nxt_aw_hold;
	wire       nxt_w_hold;
	wire       nxt_bvalid;
	wire       nxt_rvalid;
	wire [7:0] rd_byte;

	assign aw_take  = AWVALID_I & awready_ff;
	assign w_take   = WVALID_I & wready_ff;
	assign aw_have  = aw_hold_ff | aw_take;
	assign w_have   = w_hold_ff | w_take;
	assign do_write = aw_have & w_have & ~bvalid_ff;
	assign wr_idx   = aw_hold_ff ? aw_idx_ff : AWADDR_I[6:2];
	assign wr_data  = w_hold_ff ? w_data_ff : WDATA_I[7:0];
	assign wr_strb  = w_hold_ff ? w_strb_ff : WSTRB_I[0];

	assign nxt_aw_hold = aw_have & ~do_write;
	assign nxt_w_hold  = w_have & ~do_write;
	assign nxt_bvalid  = do_write | (bvalid_ff & ~BREADY_I);

	assign ar_take    = ARVALID_I & arready_ff;
	assign rd_idx     = ARADDR_I[6:2];
	assign nxt_rvalid = ar_take | (rvalid_ff & ~RREADY_I);
	assign rb_ctl     = reg_q[`ADM_IDX_READBACK_CTL];
	assign rb_value   = (rb_ctl[`ADM_RB_INDEX_MSB:5] == 2'h0) ?
		reg_q[rb_ctl[4:0]] : 8'h00;
	assign rb_pop     = ar_take & (rd_idx == `ADM_IDX_READBACK_DATA) &
		rb_ctl[`ADM_RB_AUTOINC_BIT];
	assign rd_byte    = (rd_idx == `ADM_IDX_READBACK_DATA) ?
		rb_value : reg_q[rd_idx];

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : g_reg
			if ((i >= 1 && i <= 12) || (i >= 16 && i <= 19))
			begin : g_map
				reg  [7:0] val_ff;
				reg  [7:0] nxt_val;
				wire       wr_hit;
				assign wr_hit   = do_write & wr_strb & (wr_idx == i);
				assign reg_q[i] = val_ff;
				always @*
				begin
					nxt_val = val_ff;
					if (i == `ADM_IDX_READBACK_CTL && rb_pop)
						nxt_val = {val_ff[7], val_ff[6:0] + 7'h01};
					if (wr_hit)
						nxt_val = wr_data;
				end
				always @(posedge CLK_SYS_I or negedge ARST_N_I)
				begin
					if (!ARST_N_I)
					begin
						if ((i >= `ADM_IDX_ATTEN_CH1 &&
							i <= `ADM_IDX_ATTEN_CH6) ||
							i == `ADM_IDX_ATTEN_CH7 ||
							i == `ADM_IDX_ATTEN_CH8)
							val_ff <= `ADM_RST_ATTEN;
						else if (i == `ADM_IDX_READBACK_CTL)
							val_ff <= `ADM_RST_READBACK_CTL;
						else
							val_ff <= `ADM_RST_OTHER;
					end
					else
					begin
						val_ff <= nxt_val;
					end
				end
			end
			else
			begin : g_hole
				assign reg_q[i] = 8'h00;
			end
		end
	endgenerate

	always @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			aw_hold_ff <= 1'b0;
			aw_idx_ff  <= 5'h00;
			w_hold_ff  <= 1'b0;
			w_data_ff  <= 8'h00;
			w_strb_ff  <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
		end
		else
		begin
			awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			if (aw_take)
				aw_idx_ff <= AWADDR_I[6:2];
			if (w_take)
			begin
				w_data_ff <= WDATA_I[7:0];
				w_strb_ff <= WSTRB_I[0];
			end
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take)
				rdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	always @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			gain_ff    <= {8{`ADM_RST_ATTEN}};
			silence_ff <= 8'h00;
			enable_ff  <= 8'h3f;
			fmt_ff     <= `ADM_RST_OTHER;
			deemph_ff  <= `ADM_RST_OTHER;
			spare_ff   <= `ADM_RST_OTHER;
			shared_ff  <= 6'h00;
		end
		else
		begin
			gain_ff    <= {reg_q[`ADM_IDX_ATTEN_CH8],
				reg_q[`ADM_IDX_ATTEN_CH7], reg_q[6], reg_q[5],
				reg_q[4], reg_q[3], reg_q[2],
				reg_q[`ADM_IDX_ATTEN_CH1]};
			silence_ff <= {reg_q[`ADM_IDX_MUTE_HIGH][1:0],
				reg_q[`ADM_IDX_MUTE_LOW][5:0]};
			enable_ff  <= {reg_q[`ADM_IDX_CHAN_EN_HIGH][1:0],
				~reg_q[`ADM_IDX_CHAN_EN_LOW][5:0]};
			fmt_ff     <= reg_q[`ADM_IDX_FMT_FILT];
			deemph_ff  <= reg_q[`ADM_IDX_DEEMPH_PHASE];
			spare_ff   <= reg_q[`ADM_IDX_SPARE_OUT_CTL];
			if (reg_q[`ADM_IDX_SPARE_OUT_CTL][`ADM_SPARE_EN_BIT])
				shared_ff <= reg_q[`ADM_IDX_SPARE_OUT_CTL][5:0];
			else
				shared_ff <= ZERO_DET_I ^ {6{reg_q[
					`ADM_IDX_DEEMPH_PHASE][`ADM_ZERO_POL_BIT]}};
		end
	end

	assign AWREADY_O          = awready_ff;
	assign WREADY_O           = wready_ff;
	assign BVALID_O           = bvalid_ff;
	assign BRESP_O            = `ADM_RESP_OKAY;
	assign ARREADY_O          = arready_ff;
	assign RVALID_O           = rvalid_ff;
	assign RDATA_O            = rdata_ff;
	assign RRESP_O            = `ADM_RESP_OKAY;
	assign GAIN_STEP_O        = gain_ff;
	assign SILENCE_MASK_O     = silence_ff;
	assign CHAN_ENABLE_O      = enable_ff;
	assign INTERFACE_LAYOUT_O = fmt_ff[`ADM_FMT_MSB:`ADM_FMT_LSB];
	assign ROLLOFF_SELECT_O   = fmt_ff[`ADM_ROLLOFF_BIT];
	assign DEEMPH_ON_O        = deemph_ff[`ADM_DEEMPH_ON_BIT];
	assign DEEMPH_RATE_O      =
		deemph_ff[`ADM_DEEMPH_RATE_MSB:`ADM_DEEMPH_RATE_LSB];
	assign OUTPUT_INVERT_O    = deemph_ff[`ADM_OUT_INVERT_BIT];
	assign OVERSAMPLE_O       = spare_ff[`ADM_OVERSAMPLE_BIT];
	assign SHARED_PIN_O       = shared_ff;

endmodule // adm_regs

// file: tb/adm_regs_chk.sv
`timescale 1ns/1ns
module adm_regs_chk
(
	input wire        CLK_SYS_I,
	input wire        ARST_N_I,
	input wire        AWVALID_I,
	input wire        AWREADY_O,
	input wire [6:0]  AWADDR_I,
	input wire        WVALID_I,
	input wire        WREADY_O,
	input wire [31:0] WDATA_I,
	input wire        BVALID_O,
	input wire        BREADY_I,
	input wire        ARVALID_I,
	input wire        ARREADY_O,
	input wire        RVALID_O,
	input wire        RREADY_I,
	input wire [31:0] RDATA_O,
	input wire [63:0] GAIN_STEP_O,
	input wire [7:0]  CHAN_ENABLE_O
);
	wire wr = AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!ARST_N_I);
	AST_RST_VAL:
	assert property ($rose(ARST_N_I) |-> &GAIN_STEP_O
		&& CHAN_ENABLE_O == 8'h3f) else $error("bad reset value");
	AST_GAIN_CH1:
	assert property (wr && AWADDR_I == 7'h04 |-> ##2 GAIN_STEP_O[7:0]
		== $past(WDATA_I[7:0], 2)) else $error("gain not written");
	AST_EN_CAUSE:
	assert property (!$stable(CHAN_ENABLE_O) |-> $past(wr, 2))
		else $error("enable changed without write");
	AST_B_RISE:
	assert property (wr |=> BVALID_O && !AWREADY_O && !WREADY_O)
		else $error("no write answer");
	AST_B_HOLD:
	assert property (BVALID_O && !BREADY_I |=> BVALID_O)
		else $error("write answer dropped");
	AST_B_DONE:
	assert property (BVALID_O && BREADY_I |=> !BVALID_O && AWREADY_O)
		else $error("write answer not retired");
	AST_R_RISE:
	assert property (ARVALID_I && ARREADY_O |=> RVALID_O
		&& RDATA_O[31:8] == 24'h0) else $error("bad read answer");
	AST_R_HOLD:
	assert property (RVALID_O && !RREADY_I |=> RVALID_O
		&& $stable(RDATA_O)) else $error("read answer not held");
endmodule // adm_regs_chk

bind adm_regs adm_regs_chk u_chk (.CLK_SYS_I(CLK_SYS_I),
	.ARST_N_I(ARST_N_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
	.AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
	.WDATA_I(WDATA_I), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
	.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
	.RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .GAIN_STEP_O(GAIN_STEP_O),
	.CHAN_ENABLE_O(CHAN_ENABLE_O));

// file: tb/adm_regs_bench.sv
`timescale 1ns/1ns
module adm_regs_bench;
	reg         clk = 1'b0, arst_n = 1'b0, aw_v = 1'b0, w_v = 1'b0;
	reg         b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	reg  [6:0]  aw_a = 7'h00, ar_a = 7'h00;
	reg  [31:0] w_d = 32'h0;
	reg  [3:0]  w_s = 4'h1;
	reg  [5:0]  zd = 6'h15;
	wire        aw_r, w_r, b_v, ar_r, r_v, roll, dm, inv, ovs;
	wire [1:0]  b_p, r_p, dr;
	wire [31:0] r_d;
	wire [63:0] gain;
	wire [7:0]  sil, en;
	wire [2:0]  lay;
	wire [5:0]  shp;
	integer     n_mismatch = 0, n_compared = 0, i;
	always #5 clk = ~clk;
	adm_regs DUT (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .AWVALID_I(aw_v),
		.AWREADY_O(aw_r), .AWADDR_I(aw_a), .WVALID_I(w_v), .WREADY_O(w_r),
		.WDATA_I(w_d), .WSTRB_I(w_s), .BVALID_O(b_v), .BREADY_I(b_r),
		.BRESP_O(b_p), .ARVALID_I(ar_v), .ARREADY_O(ar_r), .ARADDR_I(ar_a),
		.RVALID_O(r_v), .RREADY_I(r_r), .RDATA_O(r_d), .RRESP_O(r_p),
		.ZERO_DET_I(zd), .GAIN_STEP_O(gain), .SILENCE_MASK_O(sil),
		.CHAN_ENABLE_O(en), .INTERFACE_LAYOUT_O(lay), .ROLLOFF_SELECT_O(roll),
		.DEEMPH_ON_O(dm), .DEEMPH_RATE_O(dr), .OUTPUT_INVERT_O(inv),
		.OVERSAMPLE_O(ovs), .SHARED_PIN_O(shp));
	task chk(input [63:0] got, input [63:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [6:0] a, input [7:0] d);
	begin
		aw_v <= 1'b1;
		w_v <= 1'b1;
		aw_a <= a;
		w_d <= {24'h0, d};
		do @(posedge clk); while (!(aw_r && w_r));
		aw_v <= 1'b0;
		w_v <= 1'b0;
		do @(posedge clk); while (!b_v);
		b_r <= 1'b1;
		@(posedge clk);
		b_r <= 1'b0;
		@(posedge clk);
	end
	endtask
	task rd(input [6:0] a, input [31:0] e);
	begin
		ar_v <= 1'b1;
		ar_a <= a;
		do @(posedge clk); while (!ar_r);
		ar_v <= 1'b0;
		do @(posedge clk); while (!r_v);
		r_r <= 1'b1;
		@(posedge clk);
		r_r <= 1'b0;
		chk({r_p, r_d}, {2'h0, e});
	end
	endtask
	task t_reset;
	begin
		for (i = 0; i < 20; i = i + 1)
			rd({i[4:0], 2'b00}, (i > 0 && i < 7 || i == 16 || i == 17) ?
				32'hff : {31'h0, i == 11});
		chk(gain, {8{8'hff}});
		chk({sil, en, lay, roll, dm, dr, inv, ovs, shp},
			{8'h00, 8'h3f, 9'h000, 6'h15});
	end
	endtask
	task t_write;
	begin
		wr(7'h04, 8'h12);
		wr(7'h44, 8'h00);
		wr(7'h48, 8'h03);
		wr(7'h20, 8'h3f);
		wr(7'h4c, 8'h03);
		wr(7'h24, 8'h17);
		chk(gain, {8'h00, {6{8'hff}}, 8'h12});
		chk({sil[7:6], en, lay, roll, shp},
			{2'h3, 8'hc0, 3'h7, 1'b1, 6'h15});
		wr(7'h28, 8'h73);
		chk({dr, dm, inv, shp}, {2'h3, 2'h3, 6'h2a});
		wr(7'h30, 8'hcc);
		chk({shp, ovs}, {6'h0c, 1'b1});
	end
	endtask
	task t_index;
	begin
		wr(7'h34, 8'h55);
		rd(7'h34, 32'h0);
		wr(7'h2c, 8'h81);
		rd(7'h50, 32'h12);
		rd(7'h50, 32'hff);
		rd(7'h2c, 32'h83);
		wr(7'h2c, 8'h11);
		rd(7'h50, 32'h0);
		rd(7'h2c, 32'h11);
	end
	endtask
	task test_done;
	begin
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_write;
		t_index;
		test_done;
	end
	initial
	begin
		#20000;
		n_mismatch = n_mismatch + 1;
		test_done;
	end
endmodule // adm_regs_bench
